// [ecrs_pkg.sv]
// Package with field positions, codes and cycle counts for the reference sequencer.
`default_nettype none
package ecrs_pkg;
   localparam int unsigned CLK_SEL_HI_BIT  = 5;
   localparam int unsigned CLK_SEL_LO_BIT  = 4;
   localparam int unsigned REF_SEL_HI_BIT  = 3;
   localparam int unsigned REF_SEL_LO_BIT  = 2;
   localparam logic [1:0]  CLK_MODE_EXT    = 2'h3;
   localparam logic [1:0]  CLK_SEL_RESET   = 2'h2;
   localparam logic [1:0]  REF_SEL_RESET   = 2'h2;
   localparam int unsigned CHAN_WAKE_CYC   = 218;
   localparam int unsigned TEMP_WAKE_CYC   = 244;
   localparam int unsigned TEMP_OUT_CYC    = 188;
   localparam int unsigned CNT_W           = 9;

   // Codes 00 and 10 run the converter from the internal reference.
   function automatic logic ecrs_uses_internal(input logic [1:0] sel);
      return ~sel[0];
   endfunction : ecrs_uses_internal

   typedef enum logic [3:0] {
      ECRS_IDLE = 4'h1,
      ECRS_WAKE = 4'h2,
      ECRS_CONV = 4'h4,
      ECRS_TOUT = 4'h8
   } ecrs_state_t;
endpackage : ecrs_pkg
`default_nettype wire

// [ecrs_edge.sv]
// Synchroniser and rising-edge finder for the external conversion clock.
`default_nettype none
module ecrs_edge (
   // Clock and reset.
   input  wire logic clock,
   input  wire logic rst,
   // Asynchronous pin and its edge pulse.
   input  wire logic pin,
   output logic      rise
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } ecrs_edge_t;
   ecrs_edge_t st_r;
   ecrs_edge_t st_nxt;

   // Two stages settle the pin; only the third stage compares against the second.
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = pin;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // The pulse is one cycle wide, taken after the synchroniser.
   assign rise = st_r.s2 & ~st_r.s3;
endmodule : ecrs_edge
`default_nettype wire

// [ecrs_top.sv]
// Reference sequencer for the external conversion clock mode.
`default_nettype none
module ecrs_top #(
   parameter int unsigned CNT_W = ecrs_pkg::CNT_W
) (
   // Clock and reset.
   input  wire logic       clock,
   input  wire logic       rst,
   // Setup byte write from the command decoder.
   input  wire logic       setup_wr,
   input  wire logic [7:0] setup_byte,
   // External conversion clock (serial clock pin).
   input  wire logic       ext_conv_clk,
   // Conversion requests and scan end from the sequencing logic.
   input  wire logic       chan_req,
   input  wire logic       temp_req,
   input  wire logic       scan_done,
   // Status and controls.
   output logic [1:0]      clock_select,
   output logic [1:0]      reference_select,
   output logic            int_ref_on,
   output logic            busy,
   output logic            conv_start,
   output logic            temp_out_valid,
   output logic            shared_pin_is_ref
);
   typedef struct packed {
      logic [1:0]          clk_sel;
      logic [1:0]          ref_sel;
      logic                ref_on;
      logic                is_temp;
      logic [CNT_W-1:0]    cnt;
      ecrs_pkg::ecrs_state_t fsm;
      logic                start;
      logic                tvalid;
      logic                pin_ref;
      logic                busy;
      logic [CNT_W-1:0]    edges;
   } ecrs_top_t;

   ecrs_top_t st_r;
   ecrs_top_t st_nxt;
   logic      ext_rise;
   logic      ext_mode;

   ecrs_edge u_edge (
      .clock (clock),
      .rst   (rst),
      .pin   (ext_conv_clk),
      .rise  (ext_rise)
   );

   assign ext_mode = (st_r.clk_sel == ecrs_pkg::CLK_MODE_EXT);

   // Sequencer: delays count rising edges of the external conversion clock.
   always_comb begin
      st_nxt       = st_r;
      st_nxt.start = 1'b0;
      if (setup_wr && st_r.fsm == ecrs_pkg::ECRS_IDLE) begin
         st_nxt.clk_sel = setup_byte[ecrs_pkg::CLK_SEL_HI_BIT:ecrs_pkg::CLK_SEL_LO_BIT];
         st_nxt.ref_sel = setup_byte[ecrs_pkg::REF_SEL_HI_BIT:ecrs_pkg::REF_SEL_LO_BIT];
      end
      st_nxt.pin_ref = ~ecrs_pkg::ecrs_uses_internal(st_nxt.ref_sel);
      case (st_r.fsm)
         ecrs_pkg::ECRS_IDLE: begin
            if (ext_mode && temp_req) begin
               st_nxt.ref_on  = 1'b1;
               st_nxt.is_temp = 1'b1;
               st_nxt.tvalid  = 1'b0;
               st_nxt.cnt     = CNT_W'(ecrs_pkg::TEMP_WAKE_CYC);
               st_nxt.fsm     = ecrs_pkg::ECRS_WAKE;
            end else if (ext_mode && chan_req) begin
               st_nxt.is_temp = 1'b0;
               st_nxt.tvalid  = 1'b0;
               if (ecrs_pkg::ecrs_uses_internal(st_r.ref_sel) && !st_r.ref_on) begin
                  st_nxt.ref_on = 1'b1;
                  st_nxt.cnt    = CNT_W'(ecrs_pkg::CHAN_WAKE_CYC);
                  st_nxt.fsm    = ecrs_pkg::ECRS_WAKE;
               end else begin
                  // External reference: convert at once, reference untouched.
                  st_nxt.start = 1'b1;
                  st_nxt.fsm   = ecrs_pkg::ECRS_CONV;
               end
            end
         end
         ecrs_pkg::ECRS_WAKE: begin
            if (ext_rise) begin
               if (st_r.cnt == CNT_W'(1)) begin
                  st_nxt.start = 1'b1;
                  if (st_r.is_temp) begin
                     st_nxt.cnt = CNT_W'(ecrs_pkg::TEMP_OUT_CYC);
                     st_nxt.fsm = ecrs_pkg::ECRS_TOUT;
                  end else begin
                     st_nxt.fsm = ecrs_pkg::ECRS_CONV;
                  end
               end else begin
                  st_nxt.cnt = st_r.cnt - CNT_W'(1);
               end
            end
         end
         ecrs_pkg::ECRS_CONV: begin
            if (scan_done) begin
               // Shutting down saves power; next request pays the wake delay.
               if (ecrs_pkg::ecrs_uses_internal(st_r.ref_sel)) begin
                  st_nxt.ref_on = 1'b0;
               end
               st_nxt.fsm = ecrs_pkg::ECRS_IDLE;
            end
         end
         ecrs_pkg::ECRS_TOUT: begin
            if (ext_rise) begin
               if (st_r.cnt == CNT_W'(1)) begin
                  st_nxt.tvalid = 1'b1;
                  st_nxt.ref_on = 1'b0;
                  st_nxt.fsm    = ecrs_pkg::ECRS_IDLE;
               end else begin
                  st_nxt.cnt = st_r.cnt - CNT_W'(1);
               end
            end
         end
         default: begin
            st_nxt.fsm = ecrs_pkg::ECRS_IDLE;
         end
      endcase
      // Busy is registered so that the status port comes straight from a flop.
      st_nxt.busy = (st_nxt.fsm != ecrs_pkg::ECRS_IDLE);
      // Edge count since idle was left; only the checks read it, and it may wrap
      // during a long scan, a stretch that no check looks at.
      if (st_r.fsm == ecrs_pkg::ECRS_IDLE) begin
         st_nxt.edges = '0;
      end else if (ext_rise) begin
         st_nxt.edges = st_r.edges + CNT_W'(1);
      end
   end

   // State register; reset lands in clock mode 10 and the default reference mode.
   always_ff @(posedge clock) begin
      if (rst) begin
         st_r         <= '0;
         st_r.clk_sel <= ecrs_pkg::CLK_SEL_RESET;
         st_r.ref_sel <= ecrs_pkg::REF_SEL_RESET;
         st_r.fsm     <= ecrs_pkg::ECRS_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign clock_select      = st_r.clk_sel;
   assign reference_select  = st_r.ref_sel;
   assign int_ref_on        = st_r.ref_on;
   assign busy              = st_r.busy;
   assign conv_start        = st_r.start;
   assign temp_out_valid    = st_r.tvalid;
   assign shared_pin_is_ref = st_r.pin_ref;

   // Request kinds seen in idle; the edge count in the state lets the delays be
   // checked in external clock edges, the unit that the host actually supplies.
   sequence s_temp_go;
      st_r.fsm == ecrs_pkg::ECRS_IDLE && ext_mode && temp_req;
   endsequence

   sequence s_chan_wake_go;
      st_r.fsm == ecrs_pkg::ECRS_IDLE && ext_mode && chan_req && !temp_req
      && ecrs_pkg::ecrs_uses_internal(st_r.ref_sel) && !st_r.ref_on;
   endsequence

   sequence s_chan_direct_go;
      st_r.fsm == ecrs_pkg::ECRS_IDLE && ext_mode && chan_req && !temp_req
      && !ecrs_pkg::ecrs_uses_internal(st_r.ref_sel);
   endsequence

   // Acceptance: which requests power the reference and which must wait.
   a_temp_ref_on: assert property (@(posedge clock) disable iff (rst)
      s_temp_go |=> int_ref_on && busy && !conv_start)
      else $error("temperature request did not power the reference");
   a_chan_wake: assert property (@(posedge clock) disable iff (rst)
      s_chan_wake_go |=> int_ref_on && busy && !conv_start)
      else $error("channel request with the reference off did not wait");
   a_ext_no_ref: assert property (@(posedge clock) disable iff (rst)
      s_chan_direct_go |=> conv_start && !int_ref_on)
      else $error("external reference channel was delayed or powered");
   a_mode_gate: assert property (@(posedge clock) disable iff (rst)
      st_r.fsm == ecrs_pkg::ECRS_IDLE && !ext_mode |=> !busy)
      else $error("sequencer ran outside external clock mode");

   // Wake phase: the reference stays powered and the edge count lands exactly.
   a_wake_ref: assert property (@(posedge clock) disable iff (rst)
      st_r.fsm == ecrs_pkg::ECRS_WAKE |-> int_ref_on)
      else $error("reference unpowered during its wake delay");
   a_chan_wait: assert property (@(posedge clock) disable iff (rst)
      $rose(conv_start) && !st_r.is_temp && $past(st_r.fsm) == ecrs_pkg::ECRS_WAKE
      |-> st_r.edges == CNT_W'(ecrs_pkg::CHAN_WAKE_CYC))
      else $error("channel wake delay is not 218 edges");
   a_temp_wait: assert property (@(posedge clock) disable iff (rst)
      conv_start && st_r.is_temp |-> st_r.edges == CNT_W'(ecrs_pkg::TEMP_WAKE_CYC))
      else $error("temperature wake delay is not 244 edges");
   a_start_pulse: assert property (@(posedge clock) disable iff (rst)
      conv_start |=> !conv_start)
      else $error("conversion start held for more than one cycle");

   // Temperature result: 188 further edges, then the reference drops.
   a_temp_out: assert property (@(posedge clock) disable iff (rst)
      $rose(temp_out_valid) |-> $past(st_r.cnt) == CNT_W'(1)
      && $past(st_r.fsm) == ecrs_pkg::ECRS_TOUT
      && st_r.edges == CNT_W'(ecrs_pkg::TEMP_WAKE_CYC + ecrs_pkg::TEMP_OUT_CYC))
      else $error("temperature result came early");
   a_temp_end: assert property (@(posedge clock) disable iff (rst)
      $rose(temp_out_valid) |-> !int_ref_on && !busy)
      else $error("reference or sequencer still active after the result");

   // Scan end: an internal reference is shut down as soon as the scan ends.
   a_ref_off_scan: assert property (@(posedge clock) disable iff (rst)
      st_r.fsm == ecrs_pkg::ECRS_CONV && scan_done |=> !int_ref_on && !busy)
      else $error("reference stayed on after the scan");

   // Setup byte: taken only while idle; the pin role follows the reference code.
   a_pin_role: assert property (@(posedge clock) disable iff (rst)
      shared_pin_is_ref == (reference_select == 2'h1 || reference_select == 2'h3))
      else $error("shared pin role disagrees with reference code");
   a_setup_fields: assert property (@(posedge clock) disable iff (rst)
      setup_wr && !busy |=> clock_select == $past(setup_byte[5:4])
      && reference_select == $past(setup_byte[3:2]))
      else $error("setup fields not captured");
   a_setup_busy: assert property (@(posedge clock) disable iff (rst)
      setup_wr && busy |=> $stable(clock_select) && $stable(reference_select))
      else $error("setup fields changed while the sequencer was busy");
endmodule : ecrs_top
`default_nettype wire

// [ecrs_host_model.sv]
// Host model that drives the serial clock, which also serves as the conversion clock.
`default_nettype none
module ecrs_host_model (
   // Frame control from the bench.
   input  wire logic run,
   // Serial clock and a running count of its rising edges.
   output var  logic sclk,
   output var  int   edges
);
   timeunit 1ns;
   timeprecision 1ps;
   // A 320 ns period stays below the conversion clock ceiling.
   // The clock rests low between frames, so no stray edges reach the block.
   initial begin
      sclk  = 1'b0;
      edges = 0;
      #7;
      forever begin
         #160;
         sclk = run & ~sclk;
         if (sclk) edges++;
      end
   end
endmodule : ecrs_host_model
`default_nettype wire

// [tb_top.sv]
// Self-checking testbench for the reference sequencer.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clock, rst, setup_wr, chan_req, temp_req, scan_done, run, sclk;
   logic [7:0] setup_byte;
   logic [1:0] clock_select, reference_select;
   logic       int_ref_on, busy, conv_start, temp_out_valid, shared_pin_is_ref;
   int         edges, e0, err_count, checked, cyc = 0;

   ecrs_top ecrs_top_i (.clock(clock), .rst(rst), .setup_wr(setup_wr),
      .setup_byte(setup_byte), .ext_conv_clk(sclk), .chan_req(chan_req),
      .temp_req(temp_req), .scan_done(scan_done), .clock_select(clock_select),
      .reference_select(reference_select), .int_ref_on(int_ref_on), .busy(busy),
      .conv_start(conv_start), .temp_out_valid(temp_out_valid),
      .shared_pin_is_ref(shared_pin_is_ref));
   ecrs_host_model ecrs_host_model_i (.run(run), .sclk(sclk), .edges(edges));

   // Compares one value and counts it.
   task chk(input logic [8:0] seen, input logic [8:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick

   task setup(input logic [7:0] b);
      @(posedge clock);
      setup_wr   <= 1'b1;
      setup_byte <= b;
      @(posedge clock);
      setup_wr <= 1'b0;
      tick(1);
   endtask : setup

   // Kind 0 is a channel request, 1 a temperature request, 2 a scan end.
   task req(input int k);
      @(posedge clock);
      chan_req  <= (k == 0);
      temp_req  <= (k == 1);
      scan_done <= (k == 2);
      @(posedge clock);
      chan_req  <= 1'b0;
      temp_req  <= 1'b0;
      scan_done <= 1'b0;
      e0 = edges;
      #1;
   endtask : req

   // Waits for a start pulse or the result flag, looking at the current cycle
   // first: a direct start stands only in the cycle right after the request.
   // The edge count allows one edge of slack for the synchroniser's lag.
   task wait_for(input logic t, input int n, input logic refon);
      int i;
      int d;
      for (i = 0; i < 3000; i++) begin
         if ((t ? temp_out_valid : conv_start) === 1'b1) break;
         @(posedge clock);
         #1;
      end
      d  = edges - e0;
      e0 = edges;
      chk(9'((d + 1 >= n) && (d <= n + 1)), 9'h001);
      chk(9'(int_ref_on), 9'(refon));
   endtask : wait_for

   task tally_and_finish;
      if (err_count == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish

   // Free-running system clock.
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // Cuts a hang short; the whole run needs well under this many cycles.
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         tally_and_finish();
      end
   end

   // Main sequence.
   initial begin
      rst = 1'b1; setup_wr = 1'b0; setup_byte = 8'h00; chan_req = 1'b0;
      temp_req = 1'b0; scan_done = 1'b0; run = 1'b0; err_count = 0; checked = 0;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      tick(1);
      chk(9'(clock_select), 9'h002);
      chk(9'(reference_select), 9'h002);
      chk(9'(shared_pin_is_ref), 9'h000);
      chk(9'(int_ref_on), 9'h000);
      req(0);
      tick(2);
      chk(9'(busy), 9'h000);
      @(posedge clock);
      run <= 1'b1;
      // Every reference code with the external conversion clock selected.
      for (int k = 0; k < 4; k++) begin
         setup(8'h30 + 8'(4 * k));
         chk(9'(clock_select), 9'h003);
         chk(9'(reference_select), 9'(k));
         chk(9'(shared_pin_is_ref), 9'(k % 2));
         req(0);
         wait_for(1'b0, (k % 2) ? 0 : 218, !(k % 2));
         req(2);
         tick(1);
         chk(9'(int_ref_on), 9'h000);
         chk(9'(busy), 9'h000);
      end
      // Temperature under an external reference code still wakes the reference;
      // a setup byte sent while it is busy must be ignored.
      req(1);
      setup(8'h24);
      chk(9'(clock_select), 9'h003);
      chk(9'(reference_select), 9'h003);
      wait_for(1'b0, 244, 1'b1);
      wait_for(1'b1, 188, 1'b0);
      chk(9'(busy), 9'h000);
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
